// file: scof_host.sv
// Host model that sends request frames and collects response frames.
`timescale 1ns/100ps
module scof_host (
    input  wire logic       clk,
    output logic [7:0]      rxData,
    output logic            rxValid,
    output logic            rxLast,
    input  wire logic       rxReady,
    input  wire logic [7:0] txData,
    input  wire logic       txValid,
    input  wire logic       txLast,
    output logic            txReady
);
    // ****************************************************************
    // Request and response transfers.
    // ****************************************************************
    initial begin
        rxData  = 8'h00;
        rxValid = 1'b0;
        rxLast  = 1'b0;
        txReady = 1'b0;
    end

    // The data line shows the inverse of the last byte once released.
    task automatic send(input logic [7:0] b [5], input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            rxData  = b[i];
            rxValid = 1'b1;
            rxLast  = (i == n - 1);
            while (!rxReady) @(negedge clk);
        end
        @(negedge clk);
        rxData  = ~rxData;
        rxValid = 1'b0;
        rxLast  = 1'b0;
    endtask

    task automatic recv(output logic [7:0] r [6], output int n,
                        input int stall);
        n = 0;
        for (int w = 0; w < 20; w++) begin
            @(negedge clk);
            txReady = (w >= stall);
            if (txValid && txReady) begin
                r[n] = txData;
                n++;
                if (txLast) begin
                    @(negedge clk);
                    txReady = 1'b0;
                    return;
                end
            end
        end
        txReady = 1'b0;
    endtask
endmodule

// file: scof_interp.sv
// Interpreter for socket create and socket option request frames.
//
// Contract
// - Create request is type 0x40 with frame id and protocol 0/1/4.
// - A create request always gets a response, even with frame id zero.
// - Create response is type 0xC0 with frame id, socket id, status.
// - Non-zero create status reports socket id 0xFF and opens nothing.
// - Create status 0x00 ok, 0x22 unregistered, 0x31 internal, 0x32 full.
// - Create status 0x7B bad protocol, 0x7E updating, 0x85, 0x86 TLS config.
// - Option request is type 0x41 with frame, socket, option id, data.
// - Empty option data is a query; the setting stays unchanged.
// - Option request with frame id zero gets no response.
// - Option 0x00 is TLS profile, default 0, values 0..2, TLS only.
// - Option response type 0xC1 echoes frame, socket, option ids, status.
// - Option status 0x00 ok, 0x01 bad params, 0x02, 0x20 bad socket.
// - Current option value is appended only for a query.
`timescale 1ns/100ps

module scof_interp
    import scof_pkg::*;
#(
    parameter int NUM_SOCKETS = 8,
    parameter int IDX_W       = $clog2(NUM_SOCKETS)
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] rxData,
    input  wire logic       rxValid,
    input  wire logic       rxLast,
    output logic            rxReady,
    output logic [7:0]      txData,
    output logic            txValid,
    output logic            txLast,
    input  wire logic       txReady,
    input  wire logic       cellRegistered,
    input  wire logic       modemUpdating,
    input  wire logic       internalFault,
    input  wire logic       tlsConfigValid,
    input  wire logic       closeValid,
    input  wire logic [7:0] closeId,
    output logic [NUM_SOCKETS-1:0] socketOpen
);
    import scof_pkg::*;

    // ****************************************************************
    // State and storage.
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_RECV = 3'b001,
        ST_EXEC = 3'b010,
        ST_SEND = 3'b100
    } scof_state_t;

    // Identifiers at or above this count name no slot and are ignored.
    localparam logic [7:0] NUM_IDS = 8'(NUM_SOCKETS);

    scof_state_t      state;
    logic [2:0]       rxCount;
    logic [2:0]       frameLen;
    logic [7:0]       frameType;
    logic [7:0]       frameId;
    logic [7:0]       field2;
    logic [7:0]       field3;
    logic [7:0]       field4;
    logic [7:0]       respBuf [RESP_BYTES];
    logic [2:0]       respLen;
    logic [2:0]       sendIdx;
    logic [7:0]       sockProto   [NUM_SOCKETS];
    logic [7:0]       sockProfile [NUM_SOCKETS];
    logic             freeFound;
    logic [IDX_W-1:0] freeIndex;

    logic [7:0]       next_resp [RESP_BYTES];
    logic [2:0]       next_respLen;
    logic             next_send;
    logic             doOpen;
    logic             doSetProfile;
    logic [IDX_W-1:0] optIndex;

    // Socket identifiers are slot numbers, so they stay below 0xFF.
    function automatic logic [IDX_W-1:0] slotOf(input logic [7:0] id);
        return id[IDX_W-1:0];
    endfunction

    // An identifier names an open socket only if it is in range and set.
    function automatic logic idKnown(input logic [7:0] id,
                                     input logic [NUM_SOCKETS-1:0] open);
        return (id < NUM_IDS) && open[slotOf(id)];
    endfunction

    scof_free_slot #(
        .NUM_SOCKETS (NUM_SOCKETS),
        .IDX_W       (IDX_W)
    ) u_free_slot (
        .openMask  (socketOpen),
        .freeFound (freeFound),
        .freeIndex (freeIndex)
    );

    // ****************************************************************
    // Handshake outputs.
    // ****************************************************************
    // The receive side stays closed from the last request byte until the
    // last response byte is taken, or for the evaluation cycle alone when no response is sent, so frames never overlap.
    // The response byte holds while the host stalls, because the send index
    // moves only on an accepted byte.
    assign rxReady = (state == ST_RECV);
    assign txValid = (state == ST_SEND);
    assign txData  = respBuf[sendIdx];
    assign txLast  = (state == ST_SEND) && (sendIdx == respLen - 3'h1);

    // ****************************************************************
    // Request capture.
    // ****************************************************************
    // Bytes past the fifth are counted but not stored; the count saturates
    // so that an overlong frame still reads as a long one.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rxCount   <= 3'h0;
            frameLen  <= 3'h0;
            frameType <= 8'h00;
            frameId   <= 8'h00;
            field2    <= 8'h00;
            field3    <= 8'h00;
            field4    <= 8'h00;
        end else if (rxValid && rxReady) begin
            unique case (rxCount)
                3'h0: frameType <= rxData;
                3'h1: frameId   <= rxData;
                3'h2: field2    <= rxData;
                3'h3: field3    <= rxData;
                3'h4: field4    <= rxData;
                default: ;
            endcase
            if (rxLast) begin
                rxCount  <= 3'h0;
                frameLen <= (rxCount == LEN_SATURATE) ? LEN_SATURATE
                                                      : rxCount + 3'h1;
            end else if (rxCount != LEN_SATURATE) begin
                rxCount <= rxCount + 3'h1;
            end
        end
    end

    // ****************************************************************
    // Request evaluation.
    // ****************************************************************
    // The status inputs are read only in the evaluation cycle. Frame types
    // other than the two handled here leave next_send low, so such a frame
    // is consumed without any response.
    always_comb begin
        for (int i = 0; i < RESP_BYTES; i++) begin
            next_resp[i] = 8'h00;
        end
        next_respLen = 3'h0;
        next_send    = 1'b0;
        doOpen       = 1'b0;
        doSetProfile = 1'b0;
        optIndex     = slotOf(field2);
        if (frameType == FT_CREATE_REQ) begin
            next_send    = 1'b1;
            next_respLen = LEN_CREATE_RSP;
            next_resp[0] = FT_CREATE_RSP;
            next_resp[1] = frameId;
            // Earlier checks take priority over later ones.
            if (modemUpdating) begin
                next_resp[3] = CST_UPDATING;
            end else if (frameLen < LEN_CREATE_REQ ||
                         (field2 != PROTO_UDP && field2 != PROTO_TCP &&
                          field2 != PROTO_TLS)) begin
                next_resp[3] = CST_BAD_PROTO;
            end else if (!cellRegistered) begin
                next_resp[3] = CST_NOT_REG;
            end else if (field2 == PROTO_TLS && !tlsConfigValid) begin
                next_resp[3] = CST_BAD_TLS_CFG;
            end else if (internalFault) begin
                next_resp[3] = CST_INTERNAL;
            end else if (!freeFound) begin
                next_resp[3] = CST_RESOURCE;
            end else begin
                next_resp[3] = CST_OK;
            end
            if (next_resp[3] == CST_OK) begin
                doOpen       = 1'b1;
                next_resp[2] = 8'(freeIndex);
            end else begin
                next_resp[2] = SOCKET_ID_NONE;
            end
        end else if (frameType == FT_OPTION_REQ &&
                     frameLen >= LEN_OPTION_HDR) begin
            next_send    = (frameId != FRAME_ID_SILENT);
            next_respLen = LEN_OPTION_RSP;
            next_resp[0] = FT_OPTION_RSP;
            next_resp[1] = frameId;
            next_resp[2] = field2;
            next_resp[3] = field3;
            if (!idKnown(field2, socketOpen)) begin
                next_resp[4] = OST_BAD_SOCKET;
            end else if (field3 != OPT_TLS_PROFILE ||
                         sockProto[optIndex] != PROTO_TLS) begin
                next_resp[4] = OST_BAD_PARAM;
            end else if (frameLen == LEN_OPTION_HDR) begin
                next_resp[4] = OST_OK;
                next_resp[5] = sockProfile[optIndex];
                next_respLen = LEN_OPTION_RSP + 3'h1;
            end else if (frameLen != LEN_OPTION_HDR + 3'h1 ||
                         field4 > TLS_PROFILE_MAX) begin
                next_resp[4] = OST_BAD_PARAM;
            end else begin
                next_resp[4] = OST_OK;
                doSetProfile = 1'b1;
            end
        end
    end

    // ****************************************************************
    // Response buffer and sequencing.
    // ****************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < RESP_BYTES; i++) begin
                respBuf[i] <= 8'h00;
            end
            respLen <= 3'h0;
        end else if (state == ST_EXEC) begin
            respBuf <= next_resp;
            respLen <= next_respLen;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= ST_RECV;
        end else begin
            unique case (state)
                ST_RECV: begin
                    if (rxValid && rxLast) begin
                        state <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    state <= next_send ? ST_SEND : ST_RECV;
                end
                ST_SEND: begin
                    if (txReady && txLast) begin
                        state <= ST_RECV;
                    end
                end
                default: state <= ST_RECV;
            endcase
        end
    end

    // ****************************************************************
    // Send index.
    // ****************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sendIdx <= 3'h0;
        end else if (state == ST_EXEC) begin
            sendIdx <= 3'h0;
        end else if (txValid && txReady && !txLast) begin
            sendIdx <= sendIdx + 3'h1;
        end
    end

    // ****************************************************************
    // Socket table.
    // ****************************************************************
    // An allocation in the same cycle as a close was chosen from the mask
    // before the close, so it reuses the closed slot only if that slot was
    // already free; the open is applied last and wins.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            socketOpen <= '0;
        end else begin
            if (closeValid && closeId < NUM_IDS) begin
                socketOpen[slotOf(closeId)] <= 1'b0;
            end
            if (state == ST_EXEC && doOpen) begin
                socketOpen[freeIndex] <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Socket attributes.
    // ****************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_SOCKETS; i++) begin
                sockProto[i]   <= PROTO_UDP;
                sockProfile[i] <= TLS_PROFILE_RESET;
            end
        end else if (state == ST_EXEC) begin
            if (doOpen) begin
                sockProto[freeIndex]   <= field2;
                sockProfile[freeIndex] <= TLS_PROFILE_RESET;
            end
            if (doSetProfile) begin
                sockProfile[optIndex] <= field4;
            end
        end
    end
endmodule

// file: scof_interp_sva.sv
// Assertion checker for the socket create and option interpreter.
`timescale 1ns/100ps
module scof_interp_sva #(
    parameter int NUM_SOCKETS = 8
) (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [7:0] rxData,
    input wire logic       rxValid,
    input wire logic       rxLast,
    input wire logic       rxReady,
    input wire logic [7:0] txData,
    input wire logic       txValid,
    input wire logic       txLast,
    input wire logic       txReady
);
    import scof_pkg::*;
    // ****************************************************************
    // Frame tracking.
    // ****************************************************************
    logic [2:0] rxIdx;
    logic [2:0] txIdx;
    logic [7:0] reqType;
    logic [7:0] reqFid;
    logic [7:0] rspType;
    logic [7:0] sockByte;
    wire        rxTake = rxValid && rxReady;
    wire        txTake = txValid && txReady;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rxIdx   <= 3'h0;
            reqType <= 8'h00;
            reqFid  <= 8'h00;
        end else if (rxTake) begin
            rxIdx <= rxLast ? 3'h0 : rxIdx + {2'h0, rxIdx != 3'h7};
            if (rxIdx == 3'h0) reqType <= rxData;
            if (rxIdx == 3'h1) reqFid <= rxData;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            txIdx    <= 3'h0;
            rspType  <= 8'h00;
            sockByte <= 8'h00;
        end else if (txTake) begin
            txIdx <= txLast ? 3'h0 : txIdx + 3'h1;
            if (txIdx == 3'h0) rspType <= txData;
            if (txIdx == 3'h2) sockByte <= txData;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_create_end;
        rxTake && rxLast && rxIdx != 3'h0 && reqType == FT_CREATE_REQ;
    endsequence
    sequence s_opt_end;
        rxTake && rxLast && rxIdx >= 3'h3 && reqType == FT_OPTION_REQ;
    endsequence

    property p_create_answer;
        s_create_end |-> ##2 txValid && txData == FT_CREATE_RSP;
    endproperty
    property p_opt_silent;
        s_opt_end ##0 (reqFid == FRAME_ID_SILENT) |=> !txValid [*4];
    endproperty
    property p_opt_answer;
        s_opt_end ##0 (reqFid != FRAME_ID_SILENT)
            |-> ##2 txValid && txData == FT_OPTION_RSP;
    endproperty
    property p_fid_echo;
        txTake && txIdx == 3'h1 |-> txData == reqFid;
    endproperty
    property p_create_len;
        txTake && txLast && rspType == FT_CREATE_RSP |-> txIdx == 3'h3;
    endproperty
    property p_opt_len;
        txTake && txLast && rspType == FT_OPTION_RSP
            |-> txIdx inside {3'h4, 3'h5};
    endproperty
    property p_err_id;
        txTake && txLast && rspType == FT_CREATE_RSP && txData != CST_OK
            |-> sockByte == SOCKET_ID_NONE;
    endproperty
    property p_ok_id;
        txTake && txLast && rspType == FT_CREATE_RSP && txData == CST_OK
            |-> sockByte < NUM_SOCKETS;
    endproperty
    property p_tx_hold;
        txValid && !txReady |=> txValid && $stable(txData) && $stable(txLast);
    endproperty

    a_create_answer: assert property (p_create_answer)
        else $error("create frame not answered");
    a_opt_silent: assert property (p_opt_silent)
        else $error("option frame with zero id answered");
    a_opt_answer: assert property (p_opt_answer)
        else $error("option frame not answered");
    a_fid_echo: assert property (p_fid_echo)
        else $error("frame id not echoed");
    a_create_len: assert property (p_create_len)
        else $error("create response length wrong");
    a_opt_len: assert property (p_opt_len)
        else $error("option response length wrong");
    a_err_id: assert property (p_err_id)
        else $error("failed create reports a socket id");
    a_ok_id: assert property (p_ok_id)
        else $error("allocated socket id out of range");
    a_tx_hold: assert property (p_tx_hold)
        else $error("response byte changed while stalled");
endmodule

bind scof_interp scof_interp_sva #(.NUM_SOCKETS(NUM_SOCKETS)) u_scof_interp_sva (
    .clk, .rst, .rxData, .rxValid, .rxLast, .rxReady, .txData, .txValid,
    .txLast, .txReady
);

// file: scof_pkg.sv
// Package and free-slot finder for the socket create and option interpreter.
package scof_pkg;
    // ****************************************************************
    // Frame types.
    // ****************************************************************
    localparam logic [7:0] FT_CREATE_REQ = 8'h40;
    localparam logic [7:0] FT_OPTION_REQ = 8'h41;
    localparam logic [7:0] FT_CREATE_RSP = 8'hc0;
    localparam logic [7:0] FT_OPTION_RSP = 8'hc1;

    // ****************************************************************
    // Protocol choices.
    // ****************************************************************
    localparam logic [7:0] PROTO_UDP = 8'h00;
    localparam logic [7:0] PROTO_TCP = 8'h01;
    localparam logic [7:0] PROTO_TLS = 8'h04;

    // ****************************************************************
    // Creation status codes.
    // ****************************************************************
    localparam logic [7:0] CST_OK          = 8'h00;
    localparam logic [7:0] CST_NOT_REG     = 8'h22;
    localparam logic [7:0] CST_INTERNAL    = 8'h31;
    localparam logic [7:0] CST_RESOURCE    = 8'h32;
    localparam logic [7:0] CST_BAD_PROTO   = 8'h7b;
    localparam logic [7:0] CST_UPDATING    = 8'h7e;
    localparam logic [7:0] CST_UNKNOWN     = 8'h85;
    localparam logic [7:0] CST_BAD_TLS_CFG = 8'h86;

    // ****************************************************************
    // Option identifiers, values and status codes.
    // ****************************************************************
    localparam logic [7:0] OPT_TLS_PROFILE   = 8'h00;
    localparam logic [7:0] TLS_PROFILE_RESET = 8'h00;
    localparam logic [7:0] TLS_PROFILE_MAX   = 8'h02;
    localparam logic [7:0] OST_OK            = 8'h00;
    localparam logic [7:0] OST_BAD_PARAM     = 8'h01;
    localparam logic [7:0] OST_NO_VALUE      = 8'h02;
    localparam logic [7:0] OST_BAD_SOCKET    = 8'h20;
    localparam logic [7:0] SOCKET_ID_NONE    = 8'hff;
    localparam logic [7:0] FRAME_ID_SILENT   = 8'h00;

    // ****************************************************************
    // Frame lengths in bytes, counted from the frame type byte.
    // ****************************************************************
    localparam logic [2:0] LEN_CREATE_REQ = 3'h3;
    localparam logic [2:0] LEN_OPTION_HDR = 3'h4;
    localparam logic [2:0] LEN_CREATE_RSP = 3'h4;
    localparam logic [2:0] LEN_OPTION_RSP = 3'h5;
    localparam logic [2:0] LEN_SATURATE   = 3'h7;
    localparam int         RESP_BYTES     = 6;
endpackage

`timescale 1ns/100ps

module scof_free_slot #(
    parameter int NUM_SOCKETS = 8,
    parameter int IDX_W       = 3
) (
    input  wire logic [NUM_SOCKETS-1:0] openMask,
    output logic                        freeFound,
    output logic [IDX_W-1:0]            freeIndex
);
    // Lowest-numbered closed slot; scanning downward makes the lowest win.
    always_comb begin
        freeFound = 1'b0;
        freeIndex = '0;
        for (int i = NUM_SOCKETS - 1; i >= 0; i--) begin
            if (!openMask[i]) begin
                freeFound = 1'b1;
                freeIndex = IDX_W'(i);
            end
        end
    end
endmodule

// file: tb_scof_interp.sv
// Self-checking bench for the socket create and option interpreter.
`timescale 1ns/100ps
module tb_scof_interp;
    import scof_pkg::*;
    logic       clk, rst, rxValid, rxLast, rxReady, txValid, txLast, txReady;
    logic       cellRegistered, modemUpdating, internalFault, tlsConfigValid;
    logic       closeValid;
    logic [7:0] rxData, txData, closeId, socketOpen;
    logic [7:0] rsp [6];
    logic [7:0] errSt [5] = '{CST_UPDATING, CST_BAD_PROTO, CST_NOT_REG,
                              CST_BAD_TLS_CFG, CST_INTERNAL};
    int         rspLen;
    int         num_errors = 0;
    int         cmp_count = 0;
    int         cycles = 0;

    scof_interp u_scof_interp (.clk, .rst, .rxData, .rxValid, .rxLast,
        .rxReady, .txData, .txValid, .txLast, .txReady, .cellRegistered,
        .modemUpdating, .internalFault, .tlsConfigValid, .closeValid,
        .closeId, .socketOpen);
    scof_host u_scof_host (.clk, .rxData, .rxValid, .rxLast, .rxReady,
        .txData, .txValid, .txLast, .txReady);

    // ****************************************************************
    // Clock, timeout and shared tasks.
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                     exp);
        end
    endtask

    task automatic do_create(input logic [7:0] fid, proto, sid, st);
        u_scof_host.send('{FT_CREATE_REQ, fid, proto, 8'h00, 8'h00}, 3);
        u_scof_host.recv(rsp, rspLen, 0);
        check(8'(rspLen), 8'h04);
        check(rsp[0], FT_CREATE_RSP);
        check(rsp[1], fid);
        check(rsp[2], sid);
        check(rsp[3], st);
    endtask

    task automatic do_opt(input logic [7:0] fid, sock, val, input int len,
                          input int expLen, input logic [7:0] st, expVal);
        u_scof_host.send('{FT_OPTION_REQ, fid, sock, OPT_TLS_PROFILE, val},
                         len);
        u_scof_host.recv(rsp, rspLen, 3);
        check(8'(rspLen), 8'(expLen));
        if (expLen > 0) begin
            check(rsp[0], FT_OPTION_RSP);
            check(rsp[1], fid);
            check(rsp[2], sock);
            check(rsp[3], OPT_TLS_PROFILE);
            check(rsp[4], st);
        end
        if (expLen == 6) check(rsp[5], expVal);
    endtask

    // ****************************************************************
    // Test sequence.
    // ****************************************************************
    initial begin
        rst            = 1'b1;
        closeValid     = 1'b0;
        closeId        = 8'h00;
        cellRegistered = 1'b1;
        modemUpdating  = 1'b0;
        internalFault  = 1'b0;
        tlsConfigValid = 1'b1;
        repeat (20) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        check(socketOpen, 8'h00);
        do_create(8'h00, PROTO_TCP, 8'h00, CST_OK);
        do_create(8'h05, PROTO_TLS, 8'h01, CST_OK);
        check(socketOpen, 8'h03);
        $display("test create done");
        for (int k = 0; k < 5; k++) begin
            modemUpdating  = (k == 0);
            cellRegistered = (k != 2);
            tlsConfigValid = (k != 3);
            internalFault  = (k == 4);
            do_create(8'(k + 16), (k == 1) ? 8'h02 : PROTO_TLS,
                      SOCKET_ID_NONE, errSt[k]);
            check(socketOpen, 8'h03);
        end
        cellRegistered = 1'b1;
        tlsConfigValid = 1'b1;
        internalFault  = 1'b0;
        $display("test create errors done");
        do_opt(8'h07, 8'h01, 8'h00, 4, 6, OST_OK, TLS_PROFILE_RESET);
        do_opt(8'h00, 8'h01, 8'h02, 5, 0, OST_OK, 8'h00);
        do_opt(8'h08, 8'h01, 8'h03, 5, 5, OST_BAD_PARAM, 8'h00);
        do_opt(8'h09, 8'h01, 8'h00, 4, 6, OST_OK, 8'h02);
        do_opt(8'h0a, 8'h00, 8'h01, 5, 5, OST_BAD_PARAM, 8'h00);
        do_opt(8'h0b, 8'h05, 8'h00, 4, 5, OST_BAD_SOCKET, 8'h00);
        do_opt(8'h0c, 8'h01, 8'h01, 5, 5, OST_OK, 8'h00);
        u_scof_host.send('{FT_OPTION_REQ, 8'h0d, 8'h01, 8'h01, 8'h00}, 4);
        u_scof_host.recv(rsp, rspLen, 0);
        check(8'(rspLen), 8'h05);
        check(rsp[3], 8'h01);
        check(rsp[4], OST_BAD_PARAM);
        u_scof_host.send('{8'h55, 8'h0e, 8'h01, 8'h00, 8'h00}, 3);
        u_scof_host.recv(rsp, rspLen, 0);
        check(8'(rspLen), 8'h00);
        $display("test option done");
        for (int j = 2; j < 8; j++) begin
            do_create(8'(j), PROTO_UDP, 8'(j), CST_OK);
        end
        do_create(8'h20, PROTO_UDP, SOCKET_ID_NONE, CST_RESOURCE);
        check(socketOpen, 8'hff);
        closeValid = 1'b1;
        closeId    = 8'h0c;
        @(negedge clk);
        check(socketOpen, 8'hff);
        closeId    = 8'h04;
        @(negedge clk);
        closeValid = 1'b0;
        check(socketOpen, 8'hef);
        do_create(8'h21, PROTO_TCP, 8'h04, CST_OK);
        $display("test allocation done");
        print_verdict();
    end
endmodule
